// >>> verilog/rtc_irq_defines.svh
// Constants for the alarm and periodic interrupt unit
`ifndef RTC_IRQ_DEFINES_SVH
`define RTC_IRQ_DEFINES_SVH
// Register offsets
`define ENABLE_REG_ADDR   4'hE
`define FLAG_REG_ADDR     4'hF
`define REG_RESET         8'h00
// Enable register fields
`define WEEKLY_EN_BIT     7
`define DAILY_EN_BIT      6
`define SEL_MSB           2
`define SEL_LSB           0
// Flag register fields
`define DAILY_FLAG_BIT    0
`define WEEKLY_FLAG_BIT   1
`define PERIODIC_FLAG_BIT 2
// Oscillator timebase and divider
`define OSC_HZ            32768
`define DIV_BASE          17'h00100
`define DIV_WRAP          17'h080FF
// Increment delay after pulse fall, rounded up to whole oscillator cycles
`define SEC_INC_DELAY_NS  46000
`define SEC_INC_DELAY_CYC ((`SEC_INC_DELAY_NS * 64'd32768 + 64'd999999999) / 64'd1000000000)
// Adjustment: longest stretch, period in seconds, step limit
`define ADJ_MAX_US        3784
`define ADJ_MAX_CYC       ((`ADJ_MAX_US * 64'd32768) / 64'd1000000)
`define ADJ_LIMIT         (`ADJ_MAX_CYC / 64'd2)
`define ADJ_PERIOD_SEC    5'h14
// Time values that mark the periodic events (BCD)
`define BCD_ZERO          7'h00
`define BCD_DAY_ONE       6'h01
`define DAYS_PER_WEEK     3'h7
`endif

// >>> verilog/rtc_irq_pkg.sv
// Types shared by the alarm and periodic interrupt unit
package rtc_irq_pkg;

  // Periodic select codes
  typedef enum logic [2:0] {
    PSEL_OFF   = 3'b000,
    PSEL_LOW   = 3'b001,
    PSEL_2HZ   = 3'b010,
    PSEL_1HZ   = 3'b011,
    PSEL_SEC   = 3'b100,
    PSEL_MIN   = 3'b101,
    PSEL_HOUR  = 3'b110,
    PSEL_MONTH = 3'b111
  } psel_t;

  // Current time from the time counters (BCD)
  typedef struct packed {
    logic [2:0] day_of_week;
    logic [5:0] day;
    logic [5:0] hour;
    logic [6:0] minute;
    logic [6:0] second;
  } time_t;

  // Alarm settings from the alarm registers (BCD, weekday mask)
  typedef struct packed {
    logic [6:0] weekly_days;
    logic [5:0] weekly_hour;
    logic [6:0] weekly_minute;
    logic [5:0] daily_hour;
    logic [6:0] daily_minute;
  } alarm_t;

  // Word carried from the oscillator domain to the system domain
  typedef struct packed {
    logic [1:0] phase_gray;   // Quarter-second phase, gray coded
    logic       weekly_tgl;   // Weekly match event toggle
    logic       daily_tgl;    // Daily match event toggle
    logic [3:0] level_tgl;    // Month, hour, minute, second event toggles
  } cross_t;

endpackage : rtc_irq_pkg

// >>> verilog/rtc_alarm_periodic_irq.sv
// Alarm comparators, periodic interrupt generator and interrupt pins
`timescale 1ns/100ps
`include "rtc_irq_defines.svh"

module rtc_alarm_periodic_irq
  import rtc_irq_pkg::*;
#(
  parameter bit DUAL_PIN = 1'b1     // 1: two interrupt pins, 0: one shared pin
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Register port from the serial interface
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  output logic      [7:0] reg_rdata,
  input  wire logic       second_written,
  // Oscillator timebase side
  input  wire logic       osc_clk,
  input  wire time_t      cur_time,
  input  wire alarm_t     alarm_set,
  input  wire logic       adj_on,
  input  wire logic [6:0] adj_value,
  output logic            second_increment,
  // Open-drain interrupt pins
  output logic            primary_irq_pin_o,
  output logic            primary_irq_pin_oe,
  output logic            secondary_irq_pin_o,
  output logic            secondary_irq_pin_oe,
  output logic            shared_irq_pin_o,
  output logic            shared_irq_pin_oe
);

  // ------------------------------------------------------------------
  // Oscillator domain: second-write crossing
  // ------------------------------------------------------------------
  logic        wsec_tgl_ff;
  logic        wsec_s1_ff;
  logic        wsec_s2_ff;
  logic        wsec_s3_ff;
  logic        wsec_evt;

  // Toggle once per second-counter write (system domain)
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wsec_tgl_ff <= 1'b0;
    end else if (second_written) begin
      wsec_tgl_ff <= ~wsec_tgl_ff;
    end
  end

  // Two-stage synchroniser plus an edge stage
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      wsec_s1_ff <= 1'b0;
      wsec_s2_ff <= 1'b0;
      wsec_s3_ff <= 1'b0;
    end else begin
      wsec_s1_ff <= wsec_tgl_ff;
      wsec_s2_ff <= wsec_s1_ff;
      wsec_s3_ff <= wsec_s2_ff;
    end
  end

  assign wsec_evt = wsec_s2_ff ^ wsec_s3_ff;

  // ------------------------------------------------------------------
  // Oscillator domain: sub-second divider with adjustment
  // ------------------------------------------------------------------
  logic [16:0] div_ff;
  logic [16:0] nxt_div;
  logic [16:0] div_phase;
  logic [4:0]  sec20_ff;
  logic        wrap;
  logic        adj_now;
  logic signed [6:0] adj_lim;
  logic [16:0] adj_cyc;

  assign wrap    = (div_ff == `DIV_WRAP) && !wsec_evt;
  assign adj_now = adj_on && (sec20_ff == `ADJ_PERIOD_SEC - 5'h01);

  // Clamp the step so one stretch never exceeds the longest allowed time
  always_comb begin
    if ($signed(adj_value) > $signed(7'(`ADJ_LIMIT))) begin
      adj_lim = $signed(7'(`ADJ_LIMIT));
    end else if ($signed(adj_value) < -$signed(7'(`ADJ_LIMIT))) begin
      adj_lim = -$signed(7'(`ADJ_LIMIT));
    end else begin
      adj_lim = $signed(adj_value);
    end
    adj_cyc = {{9{adj_lim[6]}}, adj_lim, 1'b0};
  end

  // Next divider value: restart on write, reload on wrap, else count
  always_comb begin
    if (wsec_evt) begin
      nxt_div = `DIV_BASE;
    end else if (wrap) begin
      nxt_div = adj_now ? (`DIV_BASE - adj_cyc)
                        : `DIV_BASE;
    end else begin
      nxt_div = div_ff + 17'h00001;
    end
  end

  // Divider register
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= `DIV_BASE;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // ------------------------------------------------------------------
  // Oscillator domain: delayed second increment
  // ------------------------------------------------------------------
  logic [1:0]  inc_cnt_ff;
  logic        post_inc_ff;

  // Count down the gap between the pulse fall and the increment
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      inc_cnt_ff <= 2'h0;
    end else if (wsec_evt) begin
      inc_cnt_ff <= 2'h0;
    end else if (wrap) begin
      inc_cnt_ff <= 2'(`SEC_INC_DELAY_CYC);
    end else if (inc_cnt_ff != 2'h0) begin
      inc_cnt_ff <= inc_cnt_ff - 2'h1;
    end
  end

  // One-cycle increment pulse to the time counters
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      second_increment <= 1'b0;
      post_inc_ff      <= 1'b0;
    end else begin
      second_increment <= (inc_cnt_ff == 2'h1) && !wsec_evt;
      post_inc_ff      <= second_increment;
    end
  end

  // Seconds modulo the adjustment period while adjustment is on, else free-running modulo 32
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec20_ff <= 5'h00;
    end else if (wrap) begin
      sec20_ff <= adj_now ? 5'h00 : sec20_ff + 5'h01;
    end
  end

  // ------------------------------------------------------------------
  // Oscillator domain: level events and alarm comparators
  // ------------------------------------------------------------------
  logic [3:0]  level_tgl_ff;
  logic [3:0]  level_hit;
  logic        weekly_match;
  logic        daily_match;
  logic        weekly_prev_ff;
  logic        daily_prev_ff;
  logic        weekly_tgl_ff;
  logic        daily_tgl_ff;
  cross_t      cross_src_ff;

  // Which level events the freshly incremented time produces
  always_comb begin
    level_hit[0] = 1'b1;
    level_hit[1] = (cur_time.second == `BCD_ZERO);
    level_hit[2] = level_hit[1] && (cur_time.minute == `BCD_ZERO);
    level_hit[3] = level_hit[2] && (cur_time.hour == 6'(`BCD_ZERO))
                   && (cur_time.day == `BCD_DAY_ONE);
  end

  // Event toggles, taken right after the counters step
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_tgl_ff <= 4'h0;
    end else if (post_inc_ff) begin
      level_tgl_ff <= level_tgl_ff ^ level_hit;
    end
  end

  // Time comparators
  assign weekly_match = (cur_time.day_of_week < `DAYS_PER_WEEK)
                        && alarm_set.weekly_days[cur_time.day_of_week]
                        && (cur_time.hour == alarm_set.weekly_hour)
                        && (cur_time.minute == alarm_set.weekly_minute);
  assign daily_match  = (cur_time.hour == alarm_set.daily_hour)
                        && (cur_time.minute == alarm_set.daily_minute);

  // Only the start of a match is an event, so arming mid-match waits
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      weekly_prev_ff <= 1'b0;
      daily_prev_ff  <= 1'b0;
      weekly_tgl_ff  <= 1'b0;
      daily_tgl_ff   <= 1'b0;
    end else begin
      weekly_prev_ff <= weekly_match;
      daily_prev_ff  <= daily_match;
      if (weekly_match && !weekly_prev_ff) begin
        weekly_tgl_ff <= ~weekly_tgl_ff;
      end
      if (daily_match && !daily_prev_ff) begin
        daily_tgl_ff <= ~daily_tgl_ff;
      end
    end
  end

  // Quarter-second phase, held at zero during a lengthened start
  assign div_phase = div_ff - `DIV_BASE;

  // Launch register for the crossing word
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      cross_src_ff <= '0;
    end else begin
      cross_src_ff.phase_gray <= div_phase[16] ? 2'b00
                                 : {div_phase[14], div_phase[14] ^ div_phase[13]};
      cross_src_ff.weekly_tgl <= weekly_tgl_ff;
      cross_src_ff.daily_tgl  <= daily_tgl_ff;
      cross_src_ff.level_tgl  <= level_tgl_ff;
    end
  end

  // ------------------------------------------------------------------
  // System domain: crossing in
  // ------------------------------------------------------------------
  cross_t      cross_s1_ff;
  cross_t      cross_s2_ff;
  cross_t      cross_s3_ff;
  logic [1:0]  phase;
  logic        weekly_evt;
  logic        daily_evt;
  logic [3:0]  level_evt;

  // Two-stage synchroniser plus an edge stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cross_s1_ff <= '0;
      cross_s2_ff <= '0;
      cross_s3_ff <= '0;
    end else begin
      cross_s1_ff <= cross_src_ff;
      cross_s2_ff <= cross_s1_ff;
      cross_s3_ff <= cross_s2_ff;
    end
  end

  // Decode gray phase and toggle edges
  assign phase      = {cross_s2_ff.phase_gray[1],
                       cross_s2_ff.phase_gray[1] ^ cross_s2_ff.phase_gray[0]};
  assign weekly_evt = cross_s2_ff.weekly_tgl ^ cross_s3_ff.weekly_tgl;
  assign daily_evt  = cross_s2_ff.daily_tgl ^ cross_s3_ff.daily_tgl;
  assign level_evt  = cross_s2_ff.level_tgl ^ cross_s3_ff.level_tgl;

  // ------------------------------------------------------------------
  // System domain: control registers
  // ------------------------------------------------------------------
  logic        weekly_enable_ff;
  logic        daily_enable_ff;
  psel_t       psel_ff;
  logic        weekly_flag_ff;
  logic        daily_flag_ff;
  logic        periodic_flag_ff;
  logic        wr_enable_reg;
  logic        wr_flag_reg;
  logic        level_mode;
  logic        level_set;

  assign wr_enable_reg = reg_wr && (reg_addr == `ENABLE_REG_ADDR);
  assign wr_flag_reg   = reg_wr && (reg_addr == `FLAG_REG_ADDR);
  assign level_mode    = psel_ff[2];
  assign level_set     = level_mode && level_evt[psel_ff[1:0]];

  // Enable and select fields, cleared at power-on
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      weekly_enable_ff <= 1'b0;
      daily_enable_ff  <= 1'b0;
      psel_ff          <= PSEL_OFF;
    end else if (wr_enable_reg) begin
      weekly_enable_ff <= reg_wdata[`WEEKLY_EN_BIT];
      daily_enable_ff  <= reg_wdata[`DAILY_EN_BIT];
      psel_ff          <= psel_t'(reg_wdata[`SEL_MSB:`SEL_LSB]);
    end
  end

  // Weekly flag: set by an armed match, cleared by writing zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      weekly_flag_ff <= 1'b0;
    end else if (weekly_evt && weekly_enable_ff) begin
      weekly_flag_ff <= 1'b1;
    end else if (wr_flag_reg && !reg_wdata[`WEEKLY_FLAG_BIT]) begin
      weekly_flag_ff <= 1'b0;
    end
  end

  // Daily flag: set by an armed match, cleared by writing zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      daily_flag_ff <= 1'b0;
    end else if (daily_evt && daily_enable_ff) begin
      daily_flag_ff <= 1'b1;
    end else if (wr_flag_reg && !reg_wdata[`DAILY_FLAG_BIT]) begin
      daily_flag_ff <= 1'b0;
    end
  end

  // Periodic flag: set per selected level event, held until written zero or a non-level select code is chosen
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      periodic_flag_ff <= 1'b0;
    end else if (level_set) begin
      periodic_flag_ff <= 1'b1;
    end else if (wr_flag_reg && !reg_wdata[`PERIODIC_FLAG_BIT]) begin
      periodic_flag_ff <= 1'b0;
    end else if (!level_mode) begin
      periodic_flag_ff <= 1'b0;
    end
  end

  // Read data, registered from the addressed register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `REG_RESET;
    end else begin
      reg_rdata <= `REG_RESET;
      if (reg_addr == `ENABLE_REG_ADDR) begin
        reg_rdata[`WEEKLY_EN_BIT]          <= weekly_enable_ff;
        reg_rdata[`DAILY_EN_BIT]           <= daily_enable_ff;
        reg_rdata[`SEL_MSB:`SEL_LSB]       <= psel_ff;
      end else if (reg_addr == `FLAG_REG_ADDR) begin
        reg_rdata[`WEEKLY_FLAG_BIT]        <= weekly_flag_ff;
        reg_rdata[`DAILY_FLAG_BIT]         <= daily_flag_ff;
        reg_rdata[`PERIODIC_FLAG_BIT]      <= periodic_flag_ff;
      end
    end
  end

  // ------------------------------------------------------------------
  // System domain: interrupt pins
  // ------------------------------------------------------------------
  logic        periodic_low;
  logic        weekly_low;
  logic        daily_low;

  // Periodic output level per select code
  always_comb begin
    unique case (psel_ff)
      PSEL_OFF:   periodic_low = 1'b0;
      PSEL_LOW:   periodic_low = 1'b1;
      PSEL_2HZ:   periodic_low = !phase[0];
      PSEL_1HZ:   periodic_low = !phase[1];
      PSEL_SEC,
      PSEL_MIN,
      PSEL_HOUR,
      PSEL_MONTH: periodic_low = periodic_flag_ff;
    endcase
  end

  assign weekly_low = weekly_enable_ff && weekly_flag_ff;
  assign daily_low  = daily_enable_ff && daily_flag_ff;

  // Pin enables; open drain, so the driven level is always low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_irq_pin_oe   <= 1'b0;
      secondary_irq_pin_oe <= 1'b0;
      shared_irq_pin_oe    <= 1'b0;
    end else begin
      primary_irq_pin_oe   <= DUAL_PIN && (daily_low || periodic_low);
      secondary_irq_pin_oe <= DUAL_PIN && weekly_low;
      shared_irq_pin_oe    <= !DUAL_PIN && (daily_low || weekly_low
                                            || periodic_low);
    end
  end

  assign primary_irq_pin_o   = 1'b0;
  assign secondary_irq_pin_o = 1'b0;
  assign shared_irq_pin_o    = 1'b0;

endmodule : rtc_alarm_periodic_irq

// >>> test/rtc_irq_props.sv
// Concurrent checks on the interrupt unit ports
`timescale 1ns/100ps
`include "rtc_irq_defines.svh"

module rtc_irq_props
  import rtc_irq_pkg::*;
#(
  parameter bit DUAL_PIN = 1'b1
) (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic       osc_clk,
  input wire logic       second_increment,
  input wire logic       primary_irq_pin_o,
  input wire logic       primary_irq_pin_oe,
  input wire logic       secondary_irq_pin_o,
  input wire logic       secondary_irq_pin_oe,
  input wire logic       shared_irq_pin_o,
  input wire logic       shared_irq_pin_oe
);
  logic wr_en_reg;
  logic wr_flag_reg;

  // Write strobes decoded per register
  assign wr_en_reg   = reg_wr && (reg_addr == `ENABLE_REG_ADDR);
  assign wr_flag_reg = reg_wr && (reg_addr == `FLAG_REG_ADDR);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_pins_idle;
    $rose(reset_n) |-> !primary_irq_pin_oe && !secondary_irq_pin_oe && !shared_irq_pin_oe;
  endproperty
  a_pins_idle: assert property (p_pins_idle) else $error("pin active after reset");
  property p_drive_low;
    !primary_irq_pin_o && !secondary_irq_pin_o && !shared_irq_pin_o;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("open drain drives high");
  property p_no_shared;
    DUAL_PIN |-> !shared_irq_pin_oe;
  endproperty
  a_no_shared: assert property (p_no_shared) else $error("shared pin used");
  property p_en_unused;
    $past(reg_addr) == `ENABLE_REG_ADDR |-> reg_rdata[5:3] == 3'h0;
  endproperty
  a_en_unused: assert property (p_en_unused) else $error("enable unused bits set");
  property p_flag_unused;
    $past(reg_addr) == `FLAG_REG_ADDR |-> reg_rdata[7:3] == 5'h00;
  endproperty
  a_flag_unused: assert property (p_flag_unused) else $error("flag unused bits set");
  property p_sel_low;
    DUAL_PIN && wr_en_reg && reg_wdata[2:0] == 3'b001 |-> ##2 primary_irq_pin_oe;
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("fixed low not driven");
  property p_week_off;
    DUAL_PIN && wr_en_reg && !reg_wdata[7] |-> ##2 !secondary_irq_pin_oe;
  endproperty
  a_week_off: assert property (p_week_off) else $error("disabled alarm active");
  property p_week_clear;
    DUAL_PIN && wr_flag_reg && !reg_wdata[1] |-> ##2 !secondary_irq_pin_oe;
  endproperty
  a_week_clear: assert property (p_week_clear) else $error("cleared alarm active");
  property p_inc_pulse;
    @(posedge osc_clk) disable iff (!reset_n) second_increment |=> !second_increment [*8];
  endproperty
  a_inc_pulse: assert property (p_inc_pulse) else $error("increment too often");

  c_flag_wr: cover property (wr_flag_reg);
  c_week_pin: cover property ($rose(secondary_irq_pin_oe));
  c_pulse_sel: cover property (wr_en_reg && reg_wdata[2:0] == 3'b011);
endmodule : rtc_irq_props

// >>> test/time_keeper_model.sv
// Time counter model stepping the second on each increment pulse
`timescale 1ns/100ps

module time_keeper_model
  import rtc_irq_pkg::*;
(
  input  wire logic osc_clk,
  input  wire logic reset_n,
  input  wire logic second_increment,
  output time_t     cur_time
);
  initial cur_time = '0;

  // Load a new time between oscillator edges
  task automatic set_time(input time_t t);
    @(negedge osc_clk);
    cur_time = t;
  endtask : set_time

  // BCD second count rolls 59 over to 00
  always @(posedge osc_clk) begin
    if (reset_n && second_increment) begin
      if (cur_time.second == 7'h59) begin
        cur_time.second <= 7'h00;
      end else if (cur_time.second[3:0] == 4'h9) begin
        cur_time.second <= {cur_time.second[6:4] + 3'h1, 4'h0};
      end else begin
        cur_time.second <= cur_time.second + 7'h01;
      end
    end
  end
endmodule : time_keeper_model

// >>> test/tb_rtc_alarm_periodic_irq.sv
// Self-checking bench for the alarm and periodic interrupt unit
`timescale 1ns/100ps

module tb_rtc_alarm_periodic_irq
  import rtc_irq_pkg::*;
;
  logic       sys_clk, osc_clk, reset_n, reg_wr, second_written, adj_on;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] adj_value;
  alarm_t     alarm_set;
  time_t      cur_time;
  logic       second_increment, p_o, p_oe, s_o, s_oe, sh_o, sh_oe;
  logic [1:0] pins;
  logic [7:0] codes [3] = '{8'h04, 8'h05, 8'h07};
  int         failures = 0;
  int         compares = 0;
  int         n;

  rtc_alarm_periodic_irq #(.DUAL_PIN(1'b1)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .second_written(second_written),
    .osc_clk(osc_clk), .cur_time(cur_time), .alarm_set(alarm_set), .adj_on(adj_on),
    .adj_value(adj_value), .second_increment(second_increment),
    .primary_irq_pin_o(p_o), .primary_irq_pin_oe(p_oe), .secondary_irq_pin_o(s_o),
    .secondary_irq_pin_oe(s_oe), .shared_irq_pin_o(sh_o), .shared_irq_pin_oe(sh_oe));
  time_keeper_model model (.osc_clk(osc_clk), .reset_n(reset_n),
    .second_increment(second_increment), .cur_time(cur_time));
  assign pins = {s_oe, p_oe};

  // Clocks: system 20 ns, oscillator 12 ns with its own phase
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #6 osc_clk = ~osc_clk;
  end

  function automatic time_t tv(logic [2:0] dw, logic [5:0] d, logic [6:0] m, logic [6:0] s);
    return {dw, d, 6'h10, m, s};
  endfunction : tv

  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge sys_clk);
    reg_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(name, exp, reg_rdata);
  endtask : rd

  task automatic wait_pins(input logic [1:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && pins !== exp; i++) begin
      @(posedge sys_clk);
      #1;
    end
    // Shared pin and driven levels must stay quiet in the two-pin build
    chk("pins", {6'h00, exp}, {2'h0, sh_o, sh_oe, p_o, s_o, pins});
    if (pins !== exp) print_verdict();
  endtask : wait_pins

  // Count cycles the primary pin holds one level
  task automatic meas(input logic lvl, output int cnt);
    cnt = 0;
    while (p_oe === lvl && cnt < 30000) begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    if (cnt == 30000) begin
      failures++;
      $display("mismatch level_time expected %0d seen %0d", 29999, cnt);
      print_verdict();
    end
  endtask : meas

  task automatic sw;
    @(posedge sys_clk);
    second_written <= 1'b1;
    @(posedge sys_clk);
    second_written <= 1'b0;
  endtask : sw

  // Minute steps 30 to 31 so the alarm match rises
  task automatic step_min(input logic [2:0] dw);
    model.set_time(tv(dw, 6'h02, 7'h30, 7'h00));
    repeat (20) @(posedge sys_clk);
    model.set_time(tv(dw, 6'h02, 7'h31, 7'h00));
  endtask : step_min

  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_addr = 4'hE;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    second_written = 1'b0;
    adj_on = 1'b0;
    adj_value = 7'h00;
    alarm_set = {7'h04, 6'h10, 7'h31, 6'h10, 7'h31};
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    wait_pins(2'b00, 1);
    rd(4'hE, 8'h00, "enable_reset");
    rd(4'hF, 8'h00, "flag_reset");
    wr(4'hE, 8'hFF);
    wr(4'h3, 8'h00);
    rd(4'hE, 8'hC7, "enable_bits");
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00, "flag_write_one");
    wr(4'hE, 8'h01);
    wait_pins(2'b01, 1);
    wr(4'hE, 8'h00);
    wr(4'hE, 8'hC0);
    step_min(3'd2);
    wait_pins(2'b11, 60);
    rd(4'hF, 8'h03, "alarm_flags");
    wr(4'hF, 8'hFE);
    wait_pins(2'b10, 1);
    rd(4'hE, 8'hC0, "enable_kept");
    wr(4'hF, 8'hFC);
    wr(4'hE, 8'h00);
    wr(4'hE, 8'hC0);
    repeat (60) @(posedge sys_clk);
    rd(4'hF, 8'h00, "enable_in_match");
    step_min(3'd3);
    wait_pins(2'b01, 60);
    wr(4'hE, 8'h00);
    wait_pins(2'b00, 1);
    rd(4'hF, 8'h01, "flag_held");
    wr(4'hF, 8'h00);
    step_min(3'd2);
    repeat (60) @(posedge sys_clk);
    rd(4'hF, 8'h00, "disabled_match");
    for (int k = 0; k < 3; k++) begin
      model.set_time(tv(3'd0, 6'h01, 7'h00, (k == 0) ? 7'h10 : 7'h59));
      model.cur_time.hour = 6'h00;
      wr(4'hE, codes[k]);
      sw();
      wait_pins(2'b01, 21000);
      chk("second_step", (k == 0) ? 8'h11 : 8'h00, {1'b0, cur_time.second});
      repeat (50) @(posedge sys_clk);
      rd(4'hF, 8'h04, "level_flag");
      wr(4'hF, 8'h00);
      wait_pins(2'b00, 1);
    end
    wr(4'hE, 8'h03);
    sw();
    wait_pins(2'b01, 40);
    meas(1'b1, n);
    meas(1'b0, n);
    chk("half_1hz", 8'h01, {7'h00, n > 9819 && n < 9842});
    wr(4'hE, 8'h02);
    sw();
    wait_pins(2'b01, 40);
    meas(1'b1, n);
    meas(1'b0, n);
    chk("half_2hz", 8'h01, {7'h00, n > 4904 && n < 4927});
    wr(4'hE, 8'h00);
    wait_pins(2'b00, 1);
    print_verdict();
  end
endmodule : tb_rtc_alarm_periodic_irq

bind rtc_alarm_periodic_irq rtc_irq_props #(.DUAL_PIN(DUAL_PIN)) props_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .osc_clk(osc_clk),
  .second_increment(second_increment), .primary_irq_pin_o(primary_irq_pin_o),
  .primary_irq_pin_oe(primary_irq_pin_oe), .secondary_irq_pin_o(secondary_irq_pin_o),
  .secondary_irq_pin_oe(secondary_irq_pin_oe), .shared_irq_pin_o(shared_irq_pin_o),
  .shared_irq_pin_oe(shared_irq_pin_oe));
